// ### verilog/dss_downstream_slot_select.sv
// Downstream slot selection and channel skip registers with AHB-Lite access
//
// Operation
// - Bit n of the upper receive mask enables bus slot 24+n, so bit 7 is slot 31.
// - Slots enabled for reception are passed to the local serial audio port.
// - With no mask bit set, the local downstream slot count decides how many slots are taken.
// - Mask changes take effect only when the master raises its new-structure commit bit.
// - A 5-bit channel skip count in bits 4:0 sets how many local channels are skipped.
// - The skip count applies only if any mask bit is set and the local slot count is non-zero.
// - Three further masks with the same encoding cover slots 0-7, 8-15 and 16-23.
`timescale 1ns/1ps
module dss_downstream_slot_select (
  input wire logic mclk, // Block clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [dss_pkg::HADDR_W-1:0] haddr, // AHB byte address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [dss_pkg::DATA_W-1:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [dss_pkg::DATA_W-1:0] hrdata, // AHB read data
  input wire logic newStructureCommit, // Commit bit from upstream, async
  input wire logic [dss_pkg::LDN_W-1:0] localDownstreamSlotCount, // Local slot count
  input wire logic slotValid, // Downstream bus slot offered
  input wire logic [dss_pkg::SLOT_W-1:0] slotIndex, // Bus slot number
  input wire logic [dss_pkg::DATA_W-1:0] slotData, // Bus slot payload
  output logic slotReady, // Slot accepted or passed over
  output logic rxValid, // Received slot for the audio port
  input wire logic rxReady, // Audio port takes the slot
  output logic [dss_pkg::SLOT_W-1:0] rxSlot, // Slot number of received word
  output logic [dss_pkg::DATA_W-1:0] rxData, // Received slot payload
  input wire logic chValid, // Local port channel offered
  input wire logic chFrameStart, // Channel is first of its frame
  input wire logic [dss_pkg::CHAN_W-1:0] chData, // Local channel payload
  output logic chReady, // Channel accepted or skipped
  output logic txValid, // Channel for downstream transmission
  input wire logic txReady, // Downstream side takes it
  output logic [dss_pkg::CHAN_W-1:0] txData, // Channel payload downstream
  output logic [dss_pkg::SKIP_W-1:0] skipCountUsed // Skip count in effect
);
  localparam int RXW = dss_pkg::SLOT_W + dss_pkg::DATA_W;

  logic [dss_pkg::MASK_W-1:0] shadowMask [dss_pkg::NUM_MASKS];
  logic [dss_pkg::MASK_W*dss_pkg::NUM_MASKS-1:0] shadowVec;
  logic [dss_pkg::MASK_W*dss_pkg::NUM_MASKS-1:0] activeMask;
  logic [dss_pkg::SKIP_W-1:0] skipCount;
  logic commitLvl;
  dss_pkg::dss_commit_t cmState;
  dss_pkg::dss_commit_t next_cmState;
  logic applyMask;
  logic anyMask;
  logic skipUsed;
  logic pending;

  // Bus slave state
  logic wrPend;
  logic [dss_pkg::HADDR_W-1:0] wrAddr;
  logic addrPhase;
  logic [dss_pkg::DATA_W-1:0] next_hrdata;
  logic [dss_pkg::DATA_W-1:0] readView;

  // Data paths
  logic takeSlot;
  logic slotBufReady;
  logic [RXW-1:0] rxWord;
  logic [dss_pkg::SKIP_W-1:0] chIndex;
  logic [dss_pkg::SKIP_W-1:0] chCount;
  logic skipThis;
  logic chBufReady;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && (htrans == dss_pkg::HTRANS_NONSEQ
    || htrans == dss_pkg::HTRANS_SEQ);

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
    end else if (hready) begin
      wrPend <= addrPhase && hwrite;
      wrAddr <= haddr;
    end
  end

  // One generate per mask register; the upper one is slots 24 to 31
  genvar g;
  generate
    for (g = 0; g < dss_pkg::NUM_MASKS; g++) begin : gMask
      localparam logic [dss_pkg::HADDR_W-1:0] MADDR =
        dss_pkg::HADDR_W'(g * dss_pkg::MASK_ADDR_STEP);
      always_ff @(posedge mclk) begin
        if (rst) begin
          shadowMask[g] <= dss_pkg::MASK_RST;
        end else if (wrPend && wrAddr == MADDR) begin
          shadowMask[g] <= hwdata[dss_pkg::MASK_W-1:0];
        end
      end
      assign shadowVec[g*dss_pkg::MASK_W +: dss_pkg::MASK_W] = shadowMask[g];
    end
  endgenerate

  // Skip count takes effect at once; only masks wait for a commit
  always_ff @(posedge mclk) begin
    if (rst) begin
      skipCount <= dss_pkg::SKIP_RST;
    end else if (wrPend && wrAddr == dss_pkg::ADDR_SKIP) begin
      skipCount <= hwdata[dss_pkg::SKIP_LSB +: dss_pkg::SKIP_W];
    end
  end

  dss_sync3 uCommitSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(newStructureCommit),
    .levelOut(commitLvl)
  );

  // A commit is a rising edge of the filtered bit, so a bit left high
  // does not keep copying later writes into the active set
  always_comb begin
    next_cmState = cmState;
    case (cmState)
      dss_pkg::DSS_CM_WAIT_LOW: begin
        if (!commitLvl) begin
          next_cmState = dss_pkg::DSS_CM_WAIT_HIGH;
        end
      end
      dss_pkg::DSS_CM_WAIT_HIGH: begin
        if (commitLvl) begin
          next_cmState = dss_pkg::DSS_CM_APPLY;
        end
      end
      dss_pkg::DSS_CM_APPLY: begin
        next_cmState = dss_pkg::DSS_CM_WAIT_LOW;
      end
      default: begin
        next_cmState = dss_pkg::DSS_CM_WAIT_LOW;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmState <= dss_pkg::DSS_CM_WAIT_LOW;
    end else begin
      cmState <= next_cmState;
    end
  end

  assign applyMask = (cmState == dss_pkg::DSS_CM_APPLY);

  always_ff @(posedge mclk) begin
    if (rst) begin
      activeMask <= '0;
    end else if (applyMask) begin
      activeMask <= shadowVec;
    end
  end

  assign anyMask = |activeMask;
  assign skipUsed = anyMask && (localDownstreamSlotCount != '0);
  assign pending = (shadowVec != activeMask);

  always_ff @(posedge mclk) begin
    if (rst) begin
      skipCountUsed <= '0;
    end else begin
      skipCountUsed <= skipUsed ? skipCount : '0;
    end
  end

  // Slot selection: masks rule when any bit is set, else the slot count
  always_comb begin
    if (anyMask) begin
      takeSlot = activeMask[slotIndex];
    end else begin
      takeSlot = (dss_pkg::LDN_W'(slotIndex) < localDownstreamSlotCount);
    end
  end

  // Slots not taken here are passed over without waiting on the port
  assign slotReady = takeSlot ? slotBufReady : 1'b1;

  dss_fifo2 #(
    .W(RXW),
    .DEPTH(dss_pkg::BUF_DEPTH)
  ) uSlotBuf (
    .mclk(mclk),
    .rst(rst),
    .inValid(slotValid && takeSlot),
    .inReady(slotBufReady),
    .inData({slotIndex, slotData}),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxWord)
  );

  assign rxSlot = rxWord[RXW-1 -: dss_pkg::SLOT_W];
  assign rxData = rxWord[dss_pkg::DATA_W-1:0];

  // Channel position in the local frame; saturates so long frames stay sent
  assign chIndex = chFrameStart ? '0 : chCount;
  assign skipThis = (chIndex < skipCountUsed);
  assign chReady = skipThis ? 1'b1 : chBufReady;

  always_ff @(posedge mclk) begin
    if (rst) begin
      chCount <= '0;
    end else if (chValid && chReady) begin
      chCount <= (chIndex == '1) ? chIndex : chIndex + 1'b1;
    end
  end

  dss_fifo2 #(
    .W(dss_pkg::CHAN_W),
    .DEPTH(dss_pkg::BUF_DEPTH)
  ) uChanBuf (
    .mclk(mclk),
    .rst(rst),
    .inValid(chValid && !skipThis),
    .inReady(chBufReady),
    .inData(chData),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );

  // Read view with bypass of a write finishing in the same cycle
  always_comb begin
    readView = '0;
    case (haddr)
      dss_pkg::ADDR_MASK_FIRST,
      dss_pkg::ADDR_MASK_SECOND,
      dss_pkg::ADDR_MASK_THIRD,
      dss_pkg::ADDR_MASK_UPPER: begin
        readView[dss_pkg::MASK_W-1:0] = shadowMask[haddr[3:2]];
        if (wrPend && wrAddr == haddr) begin
          readView[dss_pkg::MASK_W-1:0] = hwdata[dss_pkg::MASK_W-1:0];
        end
      end
      dss_pkg::ADDR_SKIP: begin
        readView[dss_pkg::SKIP_W-1:0] = skipCount;
        if (wrPend && wrAddr == haddr) begin
          readView[dss_pkg::SKIP_W-1:0] = hwdata[dss_pkg::SKIP_W-1:0];
        end
      end
      dss_pkg::ADDR_STATUS: begin
        readView[dss_pkg::STAT_PENDING] = pending;
        readView[dss_pkg::STAT_MASK_MODE] = anyMask;
        readView[dss_pkg::STAT_SKIP_USED] = skipUsed;
        readView[dss_pkg::STAT_COMMIT_LVL] = commitLvl;
        readView[dss_pkg::STAT_SKIP_LSB +: dss_pkg::SKIP_W] = skipCountUsed;
      end
      dss_pkg::ADDR_ACTIVE: begin
        readView = activeMask;
      end
      default: begin
        readView = '0;
      end
    endcase
  end

  always_comb begin
    next_hrdata = hrdata;
    if (addrPhase && !hwrite) begin
      next_hrdata = readView;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= '0;
    end else begin
      hrdata <= next_hrdata;
    end
  end
endmodule

// ### common/dss_pkg.sv
// Constants and types shared by the downstream slot select block
package dss_pkg;
  localparam int HADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MASK_W = 8;
  localparam int NUM_MASKS = 4;
  localparam int SLOT_W = 5;
  localparam int SKIP_W = 5;
  localparam int LDN_W = 8;
  localparam int CHAN_W = 32;
  localparam int BUF_DEPTH = 2;
  localparam logic [HADDR_W-1:0] ADDR_MASK_FIRST = 8'h00;
  localparam logic [HADDR_W-1:0] ADDR_MASK_SECOND = 8'h04;
  localparam logic [HADDR_W-1:0] ADDR_MASK_THIRD = 8'h08;
  localparam logic [HADDR_W-1:0] ADDR_MASK_UPPER = 8'h0c;
  localparam logic [HADDR_W-1:0] ADDR_SKIP = 8'h10;
  localparam logic [HADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [HADDR_W-1:0] ADDR_ACTIVE = 8'h18;
  localparam int MASK_ADDR_STEP = 4;
  localparam logic [MASK_W-1:0] MASK_RST = 8'h00;
  localparam logic [SKIP_W-1:0] SKIP_RST = 5'h00;
  localparam int SKIP_LSB = 0;
  localparam int STAT_PENDING = 0;
  localparam int STAT_MASK_MODE = 1;
  localparam int STAT_SKIP_USED = 2;
  localparam int STAT_COMMIT_LVL = 3;
  localparam int STAT_SKIP_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {
    DSS_CM_WAIT_LOW = 2'b00,
    DSS_CM_WAIT_HIGH = 2'b01,
    DSS_CM_APPLY = 2'b11
  } dss_commit_t;
endpackage

// ### verilog/dss_sync3.sv
// Three-stage synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module dss_sync3 (
  input wire logic mclk, // Block clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pinIn, // Asynchronous level
  output logic levelOut // Filtered level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      levelOut <= 1'b0;
    end else if (s2 == s3) begin
      levelOut <= s3;
    end
  end
endmodule

// ### verilog/dss_fifo2.sv
// Small valid/ready buffer; full stalls the source, empty holds the sink
`timescale 1ns/1ps
module dss_fifo2 #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic mclk, // Block clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic inValid, // Source offers a word
  output logic inReady, // Buffer has room
  input wire logic [W-1:0] inData, // Source word
  output logic outValid, // Buffer holds a word
  input wire logic outReady, // Sink takes the word
  output logic [W-1:0] outData // Oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### testbench/dss_downstream_slot_select_sva.sv
// Port assertions for the downstream slot select block
`timescale 1ns/1ps
module dss_downstream_slot_select_sva (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic hreadyout, // Bus ready
  input wire logic hresp, // Bus response
  input wire logic [7:0] localDownstreamSlotCount, // Slot count
  input wire logic slotValid, // Slot offered
  input wire logic slotReady, // Slot accepted
  input wire logic rxValid, // Rx word
  input wire logic rxReady, // Rx taken
  input wire logic [4:0] rxSlot, // Rx slot
  input wire logic [31:0] rxData, // Rx payload
  input wire logic chValid, // Channel offered
  input wire logic chFrameStart, // Frame start
  input wire logic [31:0] chData, // Channel payload
  input wire logic chReady, // Channel accepted
  input wire logic txValid, // Tx word
  input wire logic txReady, // Tx taken
  input wire logic [31:0] txData, // Tx payload
  input wire logic [4:0] skipCountUsed // Skip in effect
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable({rxSlot, rxData}))
    else $error("rx word moved while stalled");
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx word moved while stalled");
  chk_stall_full: assert property (slotValid && !slotReady |-> rxValid)
    else $error("slot stalled with empty buffer");
  chk_skip_gate: assert property (skipCountUsed != 5'h00
    |-> $past(localDownstreamSlotCount) != 8'h00)
    else $error("skip in effect with zero slot count");
  chk_first_skip: assert property (chValid && chReady && chFrameStart
    && skipCountUsed != 5'h00 && !txValid |=> !txValid)
    else $error("first channel not skipped");
  chk_first_pass: assert property (chValid && chReady && chFrameStart
    && skipCountUsed == 5'h00 && !txValid |=> txValid && txData == $past(chData))
    else $error("first channel not passed");
  chk_reset_clear: assert property ($fell(rst) |-> !rxValid && !txValid && skipCountUsed == 5'h00)
    else $error("outputs not clear after reset");
  cover property (slotValid && !slotReady);
  cover property (chValid && chReady && chFrameStart && skipCountUsed != 5'h00);
  cover property (rxValid && rxReady);
endmodule
bind dss_downstream_slot_select dss_downstream_slot_select_sva chk (.*);

// ### testbench/dss_upstream_model.sv
// Upstream master model: commit level and downstream slot stream
`timescale 1ns/1ps
module dss_upstream_model (
  input wire logic mclk, // Clock
  input wire logic slotReady, // Slot accepted
  output logic newStructureCommit, // Commit level
  output logic slotValid, // Slot offered
  output logic [4:0] slotIndex, // Slot number
  output logic [31:0] slotData // Slot payload
);
  initial begin
    newStructureCommit = 1'b0;
    slotValid = 1'b0;
    slotIndex = 5'h00;
    slotData = 32'h00000000;
  end
  // Held high past the filter delay, then low so the next commit sees an edge
  task automatic commit();
    newStructureCommit <= 1'b1;
    repeat (8) @(posedge mclk);
    newStructureCommit <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic sendSlot(input logic [4:0] idx, input logic [31:0] d);
    slotValid <= 1'b1;
    slotIndex <= idx;
    slotData <= d;
    do @(posedge mclk); while (slotReady !== 1'b1);
    slotValid <= 1'b0;
    // Released lines invert so stale values cannot pass
    slotIndex <= ~idx;
    slotData <= ~d;
    @(posedge mclk);
  endtask
endmodule

// ### testbench/tb_dss_downstream_slot_select.sv
// Self-checking bench for the downstream slot select block
`timescale 1ns/1ps
module tb_dss_downstream_slot_select;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready, hreadyout, hresp, slotValid, slotReady, newStructureCommit;
  logic rxValid, txValid, chReady;
  logic [31:0] hrdata, slotData, rxData, txData;
  logic [4:0] slotIndex, rxSlot, skipCountUsed;
  logic [7:0] localDownstreamSlotCount = 8'h00;
  logic rxReady = 1'b0;
  logic txReady = 1'b0;
  logic chValid = 1'b0;
  logic chFrameStart = 1'b0;
  logic [31:0] chData = 32'h00000000;
  int miscompares = 0;
  int totalChecks = 0;
  assign hready = hreadyout;
  always #10 mclk = ~mclk;
  dss_upstream_model model (.mclk(mclk), .slotReady(slotReady),
    .newStructureCommit(newStructureCommit), .slotValid(slotValid),
    .slotIndex(slotIndex), .slotData(slotData));
  dss_downstream_slot_select uut (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahbPhase(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= dss_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
  endtask
  task automatic readChk(input logic [7:0] a, input logic [31:0] exp);
    ahbPhase(a, 1'b0, 32'h00000000);
    check(hrdata, exp);
  endtask
  // Ready stays up across calls; the caller lowers it after the last word
  task automatic getRx(input logic [4:0] s, input logic [31:0] d);
    rxReady <= 1'b1;
    do @(posedge mclk); while (rxValid !== 1'b1);
    check({27'h0, rxSlot}, {27'h0, s});
    check(rxData, d);
  endtask
  task automatic getTx(input logic [31:0] d);
    txReady <= 1'b1;
    do @(posedge mclk); while (txValid !== 1'b1);
    check(txData, d);
  endtask
  task automatic chFrame(input logic [31:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      chValid <= 1'b1;
      chFrameStart <= (i == 0);
      chData <= base + i;
      do @(posedge mclk); while (chReady !== 1'b1);
    end
    chValid <= 1'b0;
    chData <= ~chData;
  endtask
  task automatic skipIs(input logic [4:0] v);
    repeat (2) @(posedge mclk);
    check({27'h0, skipCountUsed}, {27'h0, v});
  endtask
  task automatic tRegs();
    for (int i = 0; i < 8; i++) readChk(8'(i * 4), 32'h00000000);
    ahbPhase(dss_pkg::ADDR_MASK_FIRST, 1'b1, 32'h00000101);
    ahbPhase(dss_pkg::ADDR_MASK_SECOND, 1'b1, 32'h00000010);
    ahbPhase(dss_pkg::ADDR_MASK_THIRD, 1'b1, 32'h00000004);
    ahbPhase(dss_pkg::ADDR_MASK_UPPER, 1'b1, 32'h00000080);
    ahbPhase(dss_pkg::ADDR_SKIP, 1'b1, 32'hffffffe2);
    ahbPhase(8'h1c, 1'b1, 32'h12345678);
    readChk(dss_pkg::ADDR_MASK_FIRST, 32'h00000001);
    readChk(dss_pkg::ADDR_MASK_UPPER, 32'h00000080);
    readChk(dss_pkg::ADDR_MASK_THIRD, 32'h00000004);
    readChk(dss_pkg::ADDR_SKIP, 32'h00000002);
    readChk(8'h1c, 32'h00000000);
    readChk(dss_pkg::ADDR_ACTIVE, 32'h00000000);
    readChk(dss_pkg::ADDR_STATUS, 32'h00000001);
    $display("test regs done");
  endtask
  task automatic tMaskRx();
    model.commit();
    readChk(dss_pkg::ADDR_ACTIVE, 32'h80041001);
    model.sendSlot(5'h00, 32'h000000c0);
    model.sendSlot(5'h01, 32'h000000c1);
    model.sendSlot(5'h18, 32'h000000d8);
    model.sendSlot(5'h1f, 32'h000000df);
    // Third taken slot must wait while two words are held
    fork
      model.sendSlot(5'h0c, 32'h000000cc);
      begin
        repeat (3) @(posedge mclk);
        getRx(5'h00, 32'h000000c0);
        getRx(5'h1f, 32'h000000df);
        getRx(5'h0c, 32'h000000cc);
      end
    join
    rxReady <= 1'b0;
    // Ready is low so the word waits for the check instead of draining early
    model.sendSlot(5'h12, 32'h000000d2);
    getRx(5'h12, 32'h000000d2);
    rxReady <= 1'b0;
    $display("test mask rx done");
  endtask
  task automatic tSkip();
    localDownstreamSlotCount <= 8'h02;
    skipIs(5'h02);
    readChk(dss_pkg::ADDR_STATUS, 32'h00000206);
    chFrame(32'h000000a0, 4);
    getTx(32'h000000a2);
    getTx(32'h000000a3);
    txReady <= 1'b0;
    localDownstreamSlotCount <= 8'h00;
    skipIs(5'h00);
    $display("test skip done");
  endtask
  task automatic tCount();
    for (int i = 0; i < 4; i++) ahbPhase(8'(i * 4), 1'b1, 32'h00000000);
    model.commit();
    readChk(dss_pkg::ADDR_ACTIVE, 32'h00000000);
    localDownstreamSlotCount <= 8'h02;
    skipIs(5'h00);
    model.sendSlot(5'h00, 32'h000000e0);
    model.sendSlot(5'h01, 32'h000000e1);
    model.sendSlot(5'h02, 32'h000000e2);
    getRx(5'h00, 32'h000000e0);
    getRx(5'h01, 32'h000000e1);
    rxReady <= 1'b0;
    chFrame(32'h000000b0, 2);
    getTx(32'h000000b0);
    getTx(32'h000000b1);
    txReady <= 1'b0;
    $display("test count done");
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    tRegs();
    tMaskRx();
    tSkip();
    tCount();
    closeOut();
  end
  // Tests need well under 1000 cycles; this margin only catches a hang
  initial begin
    #100000;
    miscompares++;
    closeOut();
  end
endmodule
